// ===== rtl/serial_params.svh
`ifndef SERIAL_PARAMS_SVH
`define SERIAL_PARAMS_SVH

// Register byte addresses
`define OFS_STATUS   8'h00
`define OFS_DIVISOR  8'h04
`define OFS_MODE     8'h08
`define OFS_CONTROL  8'h0C
`define OFS_TXDATA   8'h10
`define OFS_RXDATA   8'h14

// Status bit positions
`define F_HOLD_EMPTY 7
`define F_RX_FULL    6
`define F_OVERRUN    5
`define F_FRAMING    4
`define F_PARITY     3
`define F_TX_END     2
`define F_RX_MP      1
`define F_TX_MP      0
`define F_CLR_HI     7
`define F_CLR_LO     3

// Reset values
`define STATUS_RST   8'h84
`define DIVISOR_RST  8'hFF
`define MODE_RST     8'h00
`define CONTROL_RST  8'h00

// Mode register fields
`define M_CKS_HI     1
`define M_CKS_LO     0
`define M_MULTIPROC  2
`define M_ODD        4
`define M_PAR_EN     5
`define M_SYNC       7

// Control register fields
`define C_TX_EN      5
`define C_RX_EN      4

// Prescaler limits: 2*4^n - 1 clocks
`define PRE_LIM_0    7'h01
`define PRE_LIM_1    7'h07
`define PRE_LIM_2    7'h1F
`define PRE_LIM_3    7'h7F

// Ticks per bit, sampling point and last data bit
`define TICK_LAST    4'hF
`define TICK_MID     4'h8
`define DATA_LAST    3'h7

// AXI responses
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

`endif

// ===== rtl/serial_pkg.sv
package serial_pkg;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_MP, TX_STOP} tx_state_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_MP, RX_STOP} rx_state_t;

endpackage : serial_pkg

// ===== rtl/baud_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_params.svh"

module baud_tick_gen
(
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Rate selection
	input  wire logic [1:0] cks,
	input  wire logic [7:0] divisor,
	// Sixteen ticks per bit
	output logic            tick
);

	logic [6:0] pre_r;
	logic [6:0] pre_lim;
	logic [7:0] div_r;
	logic       pre_hit;

	always_comb
	begin
		unique case (cks)
			2'h0: pre_lim = `PRE_LIM_0;
			2'h1: pre_lim = `PRE_LIM_1;
			2'h2: pre_lim = `PRE_LIM_2;
			2'h3: pre_lim = `PRE_LIM_3;
		endcase
	end

	// Compare with >= so a smaller select never strands the counter
	assign pre_hit = (pre_r >= pre_lim);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pre_r <= 7'h00;
		else if (pre_hit)
			pre_r <= 7'h00;
		else
			pre_r <= pre_r + 7'h01;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			div_r <= 8'h00;
			tick  <= 1'b0;
		end
		else
		begin
			tick <= 1'b0;
			if (pre_hit)
			begin
				if (div_r >= divisor)
				begin
					div_r <= 8'h00;
					tick  <= 1'b1;
				end
				else
					div_r <= div_r + 8'h01;
			end
		end
	end

endmodule : baud_tick_gen

`default_nettype wire

// ===== rtl/serial_status_and_bit_rate.sv
// How it works
// R01 - Stop bit sampled low on an async character sets the framing error flag.
// R02 - Framing error clears only by reading it as one then writing zero.
// R03 - Received parity disagreeing with the odd/even selection sets the parity error flag.
// R04 - Parity error clears only by reading it as one then writing zero.
// R05 - Parity error is meaningless in sync mode or without a parity bit.
// R06 - Last bit sent with holding register empty sets transmit end; sending stops.
// R07 - Clearing the transmitter enable also sets transmit end.
// R08 - Transmit end is read-only; clears with the empty flag's read-then-zero clear.
// R09 - Software starts sending before enabling the transmit end interrupt.
// R10 - Multiprocessor format captures each received multiprocessor bit into status.
// R11 - Received multiprocessor bit holds in sync mode, non-MP format, or receiver off.
// R12 - Received multiprocessor bit is readable; writes leave it unchanged.
// R13 - Transmit multiprocessor bit is sent with the data and loads with it.
// R14 - Transmit multiprocessor bit has no effect in sync or non-MP format.
// R15 - Bit rate comes from the 8-bit divisor and the 2-bit clock select.
// R16 - Divisor loads all ones on reset and on standby entry.
// R17 - Bit period is 32 times 4^n times divisor plus one clocks.
// R18 - Writing one to status bits 7 to 3 is ignored; zero may clear.
// R19 - Empty flag sets when data moves to the shifter or transmitter is disabled.
// R20 - Clear needs a prior read as one since the last set; set beats clear.
`timescale 1ns/1ps
`default_nettype none
`include "serial_params.svh"

module serial_status_and_bit_rate
	import serial_pkg::*;
(
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Standby request, acts as a reset of the register state
	input  wire logic       standby,
	// AXI4-Lite write address
	input  wire logic       awvalid,
	output logic            awready,
	input  wire logic [7:0] awaddr,
	input  wire logic [2:0] awprot,
	// AXI4-Lite write data
	input  wire logic       wvalid,
	output logic            wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0] wstrb,
	// AXI4-Lite write response
	output logic            bvalid,
	input  wire logic       bready,
	output logic [1:0]      bresp,
	// AXI4-Lite read address
	input  wire logic       arvalid,
	output logic            arready,
	input  wire logic [7:0] araddr,
	input  wire logic [2:0] arprot,
	// AXI4-Lite read data
	input  wire logic       rvalid_unused_n,
	output logic            rvalid,
	input  wire logic       rready,
	output logic [31:0]     rdata,
	output logic [1:0]      rresp,
	// Serial line
	output logic            txd,
	input  wire logic       rxd
);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	logic       clr_all;
	logic [7:0] baud_divisor_r;
	logic [7:0] serial_mode_reg_r;
	logic [7:0] serial_control_r;
	logic [7:0] tx_holding_reg_r;
	logic [7:0] rx_data_r;
	logic [7:3] flags_r;
	logic [7:3] arm_r;
	logic [7:3] set_v;
	logic [7:3] clr_v;
	logic       transmit_end_flag_r;
	logic       rx_multiproc_bit_r;
	logic       tx_multiproc_bit_r;
	logic [7:0] serial_status;
	logic       tick;
	logic       wr_fire;
	logic       rd_fire;
	logic       wr_hit;
	logic       we_status;
	logic       rd_status;
	logic       rd_hit;
	logic [7:0] rd_val;
	logic       transmitter_enable;
	logic       receiver_enable;
	logic       async_mp;
	logic       async_par;
	logic       par_odd;

	localparam logic [7:0] status_init = `STATUS_RST;

	tx_state_t  tx_st_r;
	logic [7:0] tx_shifter_r;
	logic       tx_mp_r;
	logic       tx_par_r;
	logic [2:0] tx_bit_r;
	logic [3:0] tx_tk_r;
	logic       tx_bit_end;
	logic       tx_load;
	logic       tx_done;

	rx_state_t  rx_st_r;
	logic [7:0] rx_sh_r;
	logic [2:0] rx_bit_r;
	logic [3:0] rx_tk_r;
	logic       rx_pb_r;
	logic       rx_mb_r;
	logic       rx_mid;
	logic       rx_end;
	logic       rx_stop;
	logic       rx_good;

	assign clr_all            = !aresetn || standby;
	assign transmitter_enable = serial_control_r[`C_TX_EN];
	assign receiver_enable    = serial_control_r[`C_RX_EN];
	assign async_mp  = serial_mode_reg_r[`M_MULTIPROC] && !serial_mode_reg_r[`M_SYNC];
	assign async_par = serial_mode_reg_r[`M_PAR_EN] && !async_mp && !serial_mode_reg_r[`M_SYNC];
	assign par_odd   = serial_mode_reg_r[`M_ODD];

	////////////////////////////////////////////////////////////////////////
	// Bit rate

	baud_tick_gen u_baud
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.cks     (serial_mode_reg_r[`M_CKS_HI:`M_CKS_LO]), // R15
		.divisor (baud_divisor_r),                          // R17
		.tick    (tick)
	);

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave

	// Address and data are taken together; one write at a time
	assign wr_fire = awready && awvalid && wvalid;
	assign rd_fire = arready && arvalid;
	assign wr_hit  = (awaddr == `OFS_STATUS) || (awaddr == `OFS_DIVISOR) ||
		(awaddr == `OFS_MODE) || (awaddr == `OFS_CONTROL) ||
		(awaddr == `OFS_TXDATA) || (awaddr == `OFS_RXDATA);
	assign rd_hit  = (araddr == `OFS_STATUS) || (araddr == `OFS_DIVISOR) ||
		(araddr == `OFS_MODE) || (araddr == `OFS_CONTROL) ||
		(araddr == `OFS_TXDATA) || (araddr == `OFS_RXDATA);
	assign we_status = wr_fire && wstrb[0] && (awaddr == `OFS_STATUS);
	assign rd_status = rd_fire && (araddr == `OFS_STATUS);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready <= 1'b0;
			wready  <= 1'b0;
		end
		else
		begin
			awready <= awvalid && wvalid && !awready && !bvalid;
			wready  <= awvalid && wvalid && !awready && !bvalid;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid <= 1'b0;
			bresp  <= `RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid <= 1'b1;
			bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (bready)
			bvalid <= 1'b0;
	end

	always_comb
	begin
		rd_val = 8'h00;
		unique case (araddr)
			`OFS_STATUS:  rd_val = serial_status;
			`OFS_DIVISOR: rd_val = baud_divisor_r;
			`OFS_MODE:    rd_val = serial_mode_reg_r;
			`OFS_CONTROL: rd_val = serial_control_r;
			`OFS_TXDATA:  rd_val = tx_holding_reg_r;
			`OFS_RXDATA:  rd_val = rx_data_r;
			default:      rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `RESP_OKAY;
		end
		else
		begin
			arready <= arvalid && !arready && !rvalid;
			if (rd_fire)
			begin
				rvalid <= 1'b1;
				rdata  <= {24'h00_0000, rd_val};
				rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (rready)
				rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Plain read/write registers

	always_ff @(posedge aclk)
	begin
		if (clr_all)
			baud_divisor_r <= `DIVISOR_RST; // R16
		else if (wr_fire && wstrb[0] && awaddr == `OFS_DIVISOR)
			baud_divisor_r <= wdata[7:0]; // R15
	end

	always_ff @(posedge aclk)
	begin
		if (clr_all)
		begin
			serial_mode_reg_r <= `MODE_RST;
			serial_control_r  <= `CONTROL_RST;
			tx_holding_reg_r  <= 8'h00;
		end
		else if (wr_fire && wstrb[0])
		begin
			if (awaddr == `OFS_MODE)
				serial_mode_reg_r <= wdata[7:0];
			if (awaddr == `OFS_CONTROL)
				serial_control_r <= wdata[7:0];
			if (awaddr == `OFS_TXDATA)
				tx_holding_reg_r <= wdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status flags

	assign serial_status = {flags_r, transmit_end_flag_r, rx_multiproc_bit_r, tx_multiproc_bit_r};

	assign set_v[`F_HOLD_EMPTY] = tx_load || !transmitter_enable; // R19
	assign set_v[`F_RX_FULL]    = rx_good && !flags_r[`F_RX_FULL];
	assign set_v[`F_OVERRUN]    = rx_good && flags_r[`F_RX_FULL];
	assign set_v[`F_FRAMING]    = rx_stop && !rxd; // R01
	assign set_v[`F_PARITY]     = rx_stop && async_par && (rx_pb_r != ((^rx_sh_r) ^ par_odd)); // R03 R05

	// Only zeros clear, and only after a read saw the flag high
	assign clr_v = {5{we_status}} & ~wdata[`F_CLR_HI:`F_CLR_LO] & arm_r; // R02 R04 R18 R20

	always_ff @(posedge aclk)
	begin
		if (clr_all)
			flags_r <= status_init[`F_CLR_HI:`F_CLR_LO];
		else
		begin
			for (int i = `F_CLR_LO; i <= `F_CLR_HI; i++)
			begin
				if (set_v[i])
					flags_r[i] <= 1'b1; // R20
				else if (clr_v[i])
					flags_r[i] <= 1'b0;
			end
		end
	end

	// A new set disarms, so a stale read cannot clear a fresh event
	always_ff @(posedge aclk)
	begin
		if (clr_all)
			arm_r <= 5'h00;
		else
			arm_r <= (arm_r | ({5{rd_status}} & flags_r)) & ~set_v & ~clr_v; // R20
	end

	always_ff @(posedge aclk)
	begin
		if (clr_all)
			transmit_end_flag_r <= status_init[`F_TX_END];
		else if (tx_done || !transmitter_enable)
			transmit_end_flag_r <= 1'b1; // R06 R07
		else if (clr_v[`F_HOLD_EMPTY])
			transmit_end_flag_r <= 1'b0; // R08
	end

	always_ff @(posedge aclk)
	begin
		if (clr_all)
			rx_multiproc_bit_r <= status_init[`F_RX_MP];
		else if (rx_stop && async_mp && receiver_enable)
			rx_multiproc_bit_r <= rx_mb_r; // R10 R11 R12
	end

	always_ff @(posedge aclk)
	begin
		if (clr_all)
			tx_multiproc_bit_r <= status_init[`F_TX_MP];
		else if (we_status)
			tx_multiproc_bit_r <= wdata[`F_TX_MP];
	end

	////////////////////////////////////////////////////////////////////////
	// Transmitter

	assign tx_bit_end = tick && (tx_tk_r == `TICK_LAST);
	assign tx_done    = tx_st_r == TX_STOP && tx_bit_end && flags_r[`F_HOLD_EMPTY]; // R06
	// Start only on a tick, else the start bit comes out up to one tick period short
	assign tx_load    = transmitter_enable && !flags_r[`F_HOLD_EMPTY] &&
		((tx_st_r == TX_IDLE && tick) || (tx_st_r == TX_STOP && tx_bit_end));

	always_ff @(posedge aclk)
	begin
		if (clr_all || !transmitter_enable)
		begin
			tx_st_r      <= TX_IDLE;
			tx_shifter_r <= 8'h00;
			tx_mp_r      <= 1'b0;
			tx_par_r     <= 1'b0;
			tx_bit_r     <= 3'h0;
			tx_tk_r      <= 4'h0;
		end
		else if (tx_load)
		begin
			tx_st_r      <= TX_START;
			tx_shifter_r <= tx_holding_reg_r;
			tx_mp_r      <= tx_multiproc_bit_r; // R13
			tx_par_r     <= (^tx_holding_reg_r) ^ par_odd;
			tx_bit_r     <= 3'h0;
			tx_tk_r      <= 4'h0;
		end
		else if (tick && tx_st_r != TX_IDLE)
		begin
			tx_tk_r <= tx_tk_r + 4'h1;
			if (tx_tk_r == `TICK_LAST)
			begin
				unique case (tx_st_r)
					TX_START: tx_st_r <= TX_DATA;
					TX_DATA:
					begin
						tx_shifter_r <= {1'b0, tx_shifter_r[7:1]};
						tx_bit_r     <= tx_bit_r + 3'h1;
						if (tx_bit_r == `DATA_LAST)
							tx_st_r <= async_par ? TX_PAR : (async_mp ? TX_MP : TX_STOP); // R14
					end
					TX_PAR:   tx_st_r <= TX_STOP;
					TX_MP:    tx_st_r <= TX_STOP;
					TX_STOP:  tx_st_r <= TX_IDLE; // R06
					TX_IDLE:  tx_st_r <= TX_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			txd <= 1'b1;
		else
		begin
			unique case (tx_st_r)
				TX_START: txd <= 1'b0;
				TX_DATA:  txd <= tx_shifter_r[0];
				TX_PAR:   txd <= tx_par_r;
				TX_MP:    txd <= tx_mp_r; // R13
				TX_STOP:  txd <= 1'b1;
				TX_IDLE:  txd <= 1'b1;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receiver

	assign rx_mid  = tick && (rx_tk_r == `TICK_MID);
	assign rx_end  = tick && (rx_tk_r == `TICK_LAST);
	assign rx_stop = rx_st_r == RX_STOP && rx_mid;
	// Faulty characters do not reach the data register
	assign rx_good = rx_stop && rxd && !set_v[`F_PARITY];

	always_ff @(posedge aclk)
	begin
		if (clr_all || !receiver_enable)
		begin
			rx_st_r  <= RX_IDLE;
			rx_sh_r  <= 8'h00;
			rx_bit_r <= 3'h0;
			rx_tk_r  <= 4'h0;
			rx_pb_r  <= 1'b0;
			rx_mb_r  <= 1'b0;
		end
		else if (rx_st_r == RX_IDLE)
		begin
			rx_tk_r <= 4'h0;
			rx_bit_r <= 3'h0;
			if (!rxd)
				rx_st_r <= RX_START;
		end
		else if (tick)
		begin
			rx_tk_r <= rx_tk_r + 4'h1;
			unique case (rx_st_r)
				RX_START:
				begin
					// A glitch shorter than half a bit is not a start
					if (rx_mid && rxd)
						rx_st_r <= RX_IDLE;
					else if (rx_end)
						rx_st_r <= RX_DATA;
				end
				RX_DATA:
				begin
					if (rx_mid)
						rx_sh_r <= {rxd, rx_sh_r[7:1]};
					if (rx_end)
					begin
						rx_bit_r <= rx_bit_r + 3'h1;
						if (rx_bit_r == `DATA_LAST)
							rx_st_r <= async_par ? RX_PAR : (async_mp ? RX_MP : RX_STOP);
					end
				end
				RX_PAR:
				begin
					if (rx_mid)
						rx_pb_r <= rxd;
					if (rx_end)
						rx_st_r <= RX_STOP;
				end
				RX_MP:
				begin
					if (rx_mid)
						rx_mb_r <= rxd; // R10
					if (rx_end)
						rx_st_r <= RX_STOP;
				end
				// Leaves at mid stop so the next start edge is not missed
				RX_STOP:
				begin
					if (rx_mid)
						rx_st_r <= RX_IDLE;
				end
				RX_IDLE: rx_st_r <= RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (clr_all)
			rx_data_r <= 8'h00;
		else if (rx_good && !flags_r[`F_RX_FULL])
			rx_data_r <= rx_sh_r;
	end

endmodule : serial_status_and_bit_rate

`default_nettype wire

// ===== tb/serial_line_model.sv
`timescale 1ns/1ps
`default_nettype none

module serial_line_model
#(
	parameter int BIT_CLKS = 32
)
(
	// Bench clock
	input  wire logic aclk,
	// Line seen from the remote station
	input  wire logic txd,
	output logic      rxd
);
	initial rxd = 1'b1;

	// Long idle gap lets a false start after a low stop run out
	task automatic send(input logic [8:0] bits, input int n, input logic stop);
		rxd <= 1'b0;
		repeat (BIT_CLKS) @(posedge aclk);
		for (int i = 0; i < n; i++)
		begin
			rxd <= bits[i];
			repeat (BIT_CLKS) @(posedge aclk);
		end
		rxd <= stop;
		repeat (BIT_CLKS) @(posedge aclk);
		rxd <= 1'b1;
		repeat (12 * BIT_CLKS) @(posedge aclk);
	endtask : send

	// Mid-bit samples; the stop lands in slot n
	task automatic grab(input int n, output logic [9:0] bits);
		bits = 10'h3FF;
		do @(posedge aclk); while (txd);
		repeat (BIT_CLKS / 2) @(posedge aclk);
		for (int i = 0; i <= n; i++)
		begin
			repeat (BIT_CLKS) @(posedge aclk);
			bits[i] = txd;
		end
	endtask : grab
endmodule : serial_line_model
`default_nettype wire

// ===== tb/serial_status_and_bit_rate_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_params.svh"

module serial_status_and_bit_rate_chk
#(
	parameter int BIT_CLKS = 32
)
(
	// Clock and control
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        standby,
	// Write channels
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic [7:0]  awaddr,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0]  wstrb,
	input wire logic        bvalid,
	// Read channels
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [7:0]  araddr,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic [31:0] rdata,
	// Line
	input wire logic        txd
);
	logic       wr_hs;
	logic       st_rd;
	logic [7:0] rd_addr_r;
	logic [9:0] low_cnt_r;
	logic       div_wr_r;
	logic       te_r;
	logic       st_wr_r;
	logic [7:0] prev_r;

	assign wr_hs = awvalid && awready && wvalid && wready && wstrb[0];
	assign st_rd = rvalid && rd_addr_r == `OFS_STATUS;

	always_ff @(posedge aclk)
	begin
		if (arvalid && arready)
			rd_addr_r <= araddr;
	end

	always_ff @(posedge aclk)
	begin
		low_cnt_r <= txd ? 10'h000 : low_cnt_r + 10'h001;
	end

	// Standby wipes the shadows just like reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn || standby)
		begin
			div_wr_r <= 1'b0;
			te_r     <= 1'b0;
		end
		else if (wr_hs && awaddr == `OFS_DIVISOR)
			div_wr_r <= 1'b1;
		else if (wr_hs && awaddr == `OFS_CONTROL)
			te_r <= wdata[`C_TX_EN];
	end

	// Last status read, void once anything could clear a flag
	always_ff @(posedge aclk)
	begin
		if (!aresetn || standby || (wr_hs && awaddr == `OFS_STATUS))
			st_wr_r <= 1'b1;
		else if (st_rd && rready)
		begin
			st_wr_r <= 1'b0;
			prev_r  <= rdata[7:0];
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_aw_w_pulse: assert property (awready |-> wready ##1 !awready)
		else $error("write ready not a paired pulse");
	chk_write_answer: assert property (awready |=> bvalid)
		else $error("write response late");
	chk_read_answer: assert property (arready |=> rvalid && !arready)
		else $error("read data late");
	chk_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h000000)
		else $error("read upper bytes not zero");
	chk_bit_length: assert property ($rose(txd) && te_r |-> low_cnt_r % BIT_CLKS == 0)
		else $error("low run not whole bits");
	chk_div_reset: assert property (rvalid && rd_addr_r == `OFS_DIVISOR && !div_wr_r |-> rdata[7:0] == 8'hFF)
		else $error("divisor not all ones");
	chk_flag_sticky: assert property (st_rd && !st_wr_r |-> (prev_r & ~rdata[7:0] & 8'hF8) == 8'h00)
		else $error("status flag cleared without write");
	chk_transmit_end_flag_te_off: assert property (st_rd && !te_r |-> rdata[7] && rdata[2])
		else $error("empty or end flag low with sender off");

	cov_frame: cover property ($rose(txd) && te_r);
	cov_framing: cover property (st_rd && rdata[4]);
	cov_overrun: cover property (st_rd && rdata[5]);
endmodule : serial_status_and_bit_rate_chk

bind serial_status_and_bit_rate serial_status_and_bit_rate_chk i_chk
(
	.aclk, .aresetn, .standby, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
	.wstrb, .bvalid, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .txd
);
`default_nettype wire

// ===== tb/serial_status_and_bit_rate_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module serial_status_and_bit_rate_tb_top;
	localparam int BIT = 32;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        standby = 1'b0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        arvalid = 1'b0;
	logic        bready = 1'b0;
	logic        rready = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0]  wstrb = 4'h1;
	logic        awready, wready, bvalid, arready, rvalid, txd, rxd;
	logic [1:0]  bresp, rresp, resp;
	logic [31:0] rdata;
	logic [9:0]  frame;
	int          errors = 0;
	int          checked = 0;

	always #5 aclk = ~aclk;

	serial_status_and_bit_rate i_dut
	(
		.aclk, .aresetn, .standby, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready,
		.wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0),
		.rvalid_unused_n(1'b1), .rvalid, .rready, .rdata, .rresp, .txd, .rxd
	);

	serial_line_model #(.BIT_CLKS(BIT)) i_line (.aclk, .txd, .rxd);

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		awaddr  <= a;
		wdata   <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		do @(posedge aclk); while (!awready);
		awvalid <= 1'b0;
		wvalid  <= 1'b0;
		do @(posedge aclk); while (!bvalid);
		resp = bresp;
	endtask : wr

	task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
		araddr  <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		resp = rresp;
		check(what, rdata, {24'h000000, exp});
	endtask : rd

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		bready  <= 1'b1;
		rready  <= 1'b1;
		rd("status", 8'h00, 8'h84);
		rd("divisor", 8'h04, 8'hFF);
		rd("unmapped", 8'h18, 8'h00);
		check("rresp", {30'h0, resp}, 32'h2);
		wr(8'h04, 8'h5A);
		check("bresp", {30'h0, resp}, 32'h0);
		wr(8'h18, 8'h77);
		check("bresp", {30'h0, resp}, 32'h2);
		rd("divisor", 8'h04, 8'h5A);
		check("rresp", {30'h0, resp}, 32'h0);
		wstrb <= 4'h0;
		wr(8'h04, 8'h11);
		wstrb <= 4'h1;
		rd("divisor", 8'h04, 8'h5A);
		wr(8'h00, 8'hFF);
		rd("status", 8'h00, 8'h85);
		standby <= 1'b1;
		repeat (2) @(posedge aclk);
		standby <= 1'b0;
		rd("divisor", 8'h04, 8'hFF);
		rd("status", 8'h00, 8'h84);
		// Fastest rate keeps frames at 32 clocks a bit
		wr(8'h04, 8'h00);
		wr(8'h08, 8'h04);
		wr(8'h0C, 8'h20);
		wr(8'h10, 8'hA5);
		rd("status", 8'h00, 8'h84);
		fork
			i_line.grab(9, frame);
			wr(8'h00, 8'h01);
		join
		check("mp frame", {22'h0, frame}, {22'h0, 10'h3A5});
		repeat (BIT) @(posedge aclk);
		rd("status", 8'h00, 8'h85);
		wr(8'h08, 8'h20);
		wr(8'h10, 8'h3C);
		fork
			i_line.grab(9, frame);
			wr(8'h00, 8'h01);
		join
		check("parity frame", {22'h0, frame}, {22'h0, 10'h23C});
		repeat (BIT) @(posedge aclk);
		wr(8'h10, 8'hFF);
		rd("status", 8'h00, 8'h85);
		wr(8'h00, 8'h01);
		wr(8'h0C, 8'h00);
		rd("status", 8'h00, 8'h85);
		wr(8'h0C, 8'h10);
		i_line.send(9'h155, 9, 1'b1);
		rd("status", 8'h00, 8'h8D);
		i_line.send(9'h055, 9, 1'b0);
		rd("status", 8'h00, 8'h9D);
		wr(8'h00, 8'hE7);
		rd("status", 8'h00, 8'h85);
		i_line.send(9'h155, 9, 1'b1);
		wr(8'h00, 8'h01);
		rd("status", 8'h00, 8'h8D);
		wr(8'h08, 8'h04);
		i_line.send(9'h112, 9, 1'b1);
		rd("status", 8'h00, 8'hCF);
		rd("rx data", 8'h14, 8'h12);
		wr(8'h08, 8'h20);
		i_line.send(9'h134, 9, 1'b1);
		rd("status", 8'h00, 8'hEF);
		wr(8'h00, 8'h01);
		rd("status", 8'h00, 8'h87);
		// Odd sense: 0x55 with its parity bit set is clean
		wr(8'h08, 8'h30);
		i_line.send(9'h155, 9, 1'b1);
		rd("status", 8'h00, 8'hC7);
		rd("rx data", 8'h14, 8'h55);
		// Sync mode: no MP slot, received MP bit holds
		wr(8'h08, 8'h84);
		i_line.send(9'h00F, 8, 1'b1);
		rd("status", 8'h00, 8'hE7);
		complete_run();
	end

	initial
	begin
		repeat (60000) @(posedge aclk);
		errors++;
		complete_run();
	end
endmodule : serial_status_and_bit_rate_tb_top
`default_nettype wire
